// ===== bench/cir_config_bank_bench.sv
`timescale 1ns/10ps
module cir_config_bank_bench;
    import cir_pkg::*;
    logic        clk, rst_n, dev_rst, slp, wake, stby, osc, smbp, dis;
    logic        exe, rstby, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [1:0]  win, bresp, rresp;
    logic [31:0] awa, wd, ara, rd, last_rd;
    logic [31:0] uw [5];
    logic [3:0]  ws;
    logic [15:0] cl, ch;
    logic [4:0]  opt;
    logic [33:0] expq [$];
    logic [33:0] mskq [$];
    logic [33:0] e, m;
    cir_ctrl_t   ctl;
    int          errors, checks, n, lo;

    cir_config_bank u_dut (.CORE_CLK(clk), .RESET_N(rst_n),
        .DEVICE_RESET(dev_rst), .SLEEP_ENTER(slp), .WAKE_EVENT(wake),
        .REG_STANDBY_CTRL(stby), .WATCHDOG_WINDOW_WIDTH(win),
        .SECONDARY_OSC_SELECT(osc), .SMBUS_PROTOCOL_ENABLE(smbp),
        .CONTROLS(ctl), .EXEC_ENABLE(exe), .REGULATOR_STANDBY(rstby),
        .AWVALID(awv), .AWREADY(awr), .AWADDR(awa), .AWPROT(3'h0),
        .WVALID(wv), .WREADY(wr), .WDATA(wd), .WSTRB(ws), .BVALID(bv),
        .BREADY(br), .BRESP(bresp), .ARVALID(arv), .ARREADY(arr),
        .ARADDR(ara), .ARPROT(3'h0), .RVALID(rv), .RREADY(rr), .RDATA(rd),
        .RRESP(rresp));

    task print_verdict;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task check(input logic [39:0] s, input logic [39:0] x);
        checks++;
        if (s !== x) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : check

    // results are judged on the negedge before the edge that takes them
    always @(negedge clk) begin
        if ((rv && rr) || (bv && br)) begin
            e = expq.size() != 0 ? expq.pop_front() : '1;
            m = mskq.size() != 0 ? mskq.pop_front() : '0;
            check(40'((rv && rr ? {rresp, rd} : {bresp, 32'h0}) & m),
                  40'(e));
        end
    end

    task axi_write(input logic [23:0] idx, input logic [31:0] d,
                   input logic [3:0] s, input logic [1:0] resp);
        logic ha, hw, hb;
        expq.push_back({resp, 32'h0});
        mskq.push_back({2'b11, 32'h0});
        @(posedge clk);
        awv <= 1'b1;
        awa <= {6'h0, idx, 2'b00};
        wv <= 1'b1;
        wd <= d;
        ws <= s;
        br <= 1'b1;
        hb = 1'b0;
        for (int i = 0; i < 100 && !hb; i++) begin
            @(negedge clk);
            ha = awv && awr;
            hw = wv && wr;
            hb = bv && br;
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (hb) br <= 1'b0;
        end
        if (!hb) begin errors++; print_verdict(); end
    endtask : axi_write

    task axi_read(input logic [23:0] idx, input logic [31:0] d,
                  input logic [31:0] msk, input logic [1:0] resp);
        logic ha, hb;
        expq.push_back({resp, d & msk});
        mskq.push_back({2'b11, msk});
        @(posedge clk);
        arv <= 1'b1;
        ara <= {6'h0, idx, 2'b00};
        rr <= 1'b1;
        hb = 1'b0;
        for (int i = 0; i < 100 && !hb; i++) begin
            @(negedge clk);
            ha = arv && arr;
            hb = rv && rr;
            last_rd = rd;
            @(posedge clk);
            if (ha) arv <= 1'b0;
            if (hb) rr <= 1'b0;
        end
        if (!hb) begin errors++; print_verdict(); end
    endtask : axi_read

    task wait_exec(output int cnt);
        cnt = 0;
        @(negedge clk);
        while (exe !== 1'b1) begin
            @(negedge clk);
            cnt++;
            if (cnt > 600) begin errors++; print_verdict(); end
        end
    endtask : wait_exec

    // word order of the identifier is left open, so both orders pass
    task uid_check;
        logic [119:0] a, b;
        for (int k = 0; k < 5; k++) begin
            axi_read(IDX_UID1 + 24'(2 * k), 32'h0, 32'hff000000, RESP_OKAY);
            uw[k] = last_rd;
        end
        a = {uw[4][23:0], uw[3][23:0], uw[2][23:0], uw[1][23:0], uw[0][23:0]};
        b = {uw[0][23:0], uw[1][23:0], uw[2][23:0], uw[3][23:0], uw[4][23:0]};
        check(40'(a === UID_DEF || b === UID_DEF), 40'h1);
    endtask : uid_check

    function automatic cir_ctrl_t exp_ctl(logic [31:0] c, logic d,
                                          logic [4:0] o);
        return {c, d, o[4], smbp, o[3], o[2] & osc, o[1], o[0]};
    endfunction : exp_ctl

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        void'($urandom(32'h727e03ad));
        {rst_n, dev_rst, slp, wake, stby, win, osc, smbp} = 9'h002;
        {awv, wv, br, arv, rr, ws} = 9'h000;
        {awa, wd, ara} = 96'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_exec(n);
        check(40'(ctl), 40'(exp_ctl(32'hffffffff, 1'b1, 5'h1f)));
        for (int k = 0; k < 4; k++)
            axi_read(IDX_CNTL + 24'(2 * k), 32'h00ffffff, '1, RESP_OKAY);
        axi_read(IDX_PART_IDENTITY_WORD, {16'h0, FAMILY_CODE_DEF, PART_CODE_DEF},
                 32'h0000ffff, RESP_OKAY);
        axi_read(IDX_SILICON_REVISION_WORD, {28'h0, REVISION_DEF}, 32'hf, RESP_OKAY);
        uid_check();
        axi_write(IDX_PART_IDENTITY_WORD, $urandom, 4'hf, RESP_SLVERR);
        axi_write(IDX_UID3, $urandom, 4'hf, RESP_SLVERR);
        axi_write(24'h000010, $urandom, 4'hf, RESP_DECERR);
        axi_read(24'h000010, 32'h0, '1, RESP_DECERR);
        cl = 16'($urandom);
        ch = 16'($urandom);
        dis = 1'($urandom);
        opt = 5'($urandom);
        axi_write(IDX_CNTL, {16'h0, cl}, 4'h3, RESP_OKAY);
        axi_write(IDX_CNTH, {16'h0, ch}, 4'h3, RESP_OKAY);
        axi_write(IDX_DMT, {31'h0, dis}, 4'h1, RESP_OKAY);
        axi_write(IDX_OPT, {27'h0, opt[3:0], 1'b0}, 4'h1, RESP_OKAY);
        axi_write(IDX_OPT, {21'h0, opt[4], 10'h0}, 4'h2, RESP_OKAY);
        axi_write(IDX_OPT, 32'h0, 4'hf, RESP_SLVERR);
        axi_write(IDX_CNTH, 32'h0, 4'h3, RESP_SLVERR);
        axi_read(IDX_CNTL, {16'h00ff, cl}, '1, RESP_OKAY);
        axi_read(IDX_CNTH, {16'h00ff, ch}, '1, RESP_OKAY);
        axi_read(IDX_DMT, {31'h007fffff, dis}, '1, RESP_OKAY);
        axi_read(IDX_OPT, {21'h0001fff, opt[4], 5'h1f, opt[3:0], 1'b1}, '1,
                 RESP_OKAY);
        check(40'(ctl), 40'(exp_ctl(32'hffffffff, 1'b1, 5'h1f)));
        @(posedge clk);
        dev_rst <= 1'b1;
        @(posedge clk);
        dev_rst <= 1'b0;
        repeat (3) @(posedge clk);
        wait_exec(n);
        check(40'(ctl), 40'(exp_ctl({ch, cl}, dis, opt)));
        @(posedge clk);
        osc <= 1'b0;
        smbp <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(40'(ctl), 40'(exp_ctl({ch, cl}, dis, opt)));
        axi_write(IDX_CTRL, 32'h1, 4'hf, RESP_OKAY);
        axi_read(IDX_OPT, 32'h00ffffff, '1, RESP_OKAY);
        axi_write(IDX_CNTH, {16'h0, ch}, 4'h1, RESP_SLVERR);
        axi_write(IDX_CNTL, {16'h0, ~cl}, 4'h3, RESP_OKAY);
        axi_read(IDX_CNTL, {16'h00ff, ~cl}, '1, RESP_OKAY);
        axi_read(IDX_CTRL, 32'h00001401, '1, RESP_OKAY);
        uid_check();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            stby <= k[0];
            win <= k[1:0];
            slp <= 1'b1;
            @(posedge clk);
            slp <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            check(40'(rstby), 40'(!k[0]));
            check(40'(exe), 40'h0);
            @(posedge clk);
            wake <= 1'b1;
            @(posedge clk);
            wake <= 1'b0;
            wait_exec(n);
            lo = (k[0] ? 10 : 200) + 5 * k;
            check(40'(n), 40'(lo));
        end
        print_verdict();
    end
endmodule : cir_config_bank_bench

bind cir_config_bank cir_config_bank_properties u_chk (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .DEVICE_RESET(DEVICE_RESET),
    .SECONDARY_OSC_SELECT(SECONDARY_OSC_SELECT),
    .SMBUS_PROTOCOL_ENABLE(SMBUS_PROTOCOL_ENABLE), .CONTROLS(CONTROLS),
    .EXEC_ENABLE(EXEC_ENABLE), .REGULATOR_STANDBY(REGULATOR_STANDBY),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));

// ===== bench/cir_config_bank_properties.sv
`timescale 1ns/10ps
module cir_config_bank_properties
    import cir_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RESET_N,
    input wire logic        DEVICE_RESET,
    input wire logic        SECONDARY_OSC_SELECT,
    input wire logic        SMBUS_PROTOCOL_ENABLE,
    input wire cir_ctrl_t   CONTROLS,
    input wire logic        EXEC_ENABLE,
    input wire logic        REGULATOR_STANDBY,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP
);
    localparam int MIN_HOLD = 10;
    logic [8:0] low_cnt_reg;
    logic [8:0] low_cnt_next;

    // saturates so a long sleep cannot wrap into a false short hold
    always_comb begin
        low_cnt_next = low_cnt_reg;
        if (EXEC_ENABLE) low_cnt_next = 9'h000;
        else if (low_cnt_reg != 9'h1ff) low_cnt_next = low_cnt_reg + 9'h001;
    end
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) low_cnt_reg <= 9'h000;
        else low_cnt_reg <= low_cnt_next;
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    chk_controls_hold:
    assert property (EXEC_ENABLE && $past(EXEC_ENABLE) && $past(EXEC_ENABLE, 2)
        && !$past(DEVICE_RESET) |-> $stable({CONTROLS.deadman_timeout_count,
        CONTROLS.deadman_disable, CONTROLS.smbus_level_select,
        CONTROLS.i2c_one_pin_select, CONTROLS.tamper_pin_disable,
        CONTROLS.comparator_input_relocate}))
        else $error("configuration moved while running");
    chk_smbus_copy:
    assert property (EXEC_ENABLE && $past(EXEC_ENABLE) |->
        CONTROLS.smbus_protocol_enable == $past(SMBUS_PROTOCOL_ENABLE))
        else $error("protocol enable not copied");
    chk_secondary_oscillator_gate:
    assert property (!$past(SECONDARY_OSC_SELECT) |->
        !CONTROLS.secondary_osc_high_power)
        else $error("high power without osc select");
    chk_standby_exec:
    assert property (REGULATOR_STANDBY |-> !EXEC_ENABLE)
        else $error("code runs with regulator in standby");
    chk_wake_hold:
    assert property ($rose(EXEC_ENABLE) |-> low_cnt_reg >= MIN_HOLD)
        else $error("start-up hold too short");
    chk_read_answer:
    assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read not answered");
    chk_read_stable:
    assert property (RVALID && !RREADY |=>
        RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read answer changed before taken");
    chk_write_answer:
    assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
        else $error("write not answered");
    chk_b_block:
    assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("new write taken during response");
    chk_ar_block:
    assert property (RVALID |-> !ARREADY)
        else $error("read taken during answer");
endmodule : cir_config_bank_properties

// ===== design/cir_config_bank.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps

module cir_config_bank
    import cir_pkg::*;
#(
    parameter logic [7:0]   FAMILY_CODE = FAMILY_CODE_DEF,
    parameter logic [7:0]   PART_CODE   = PART_CODE_DEF,
    parameter logic [3:0]   REVISION    = REVISION_DEF,
    parameter logic [119:0] UNIQUE_ID   = UID_DEF
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,

    input  wire logic        DEVICE_RESET,
    input  wire logic        SLEEP_ENTER,
    input  wire logic        WAKE_EVENT,
    input  wire logic        REG_STANDBY_CTRL,
    input  wire logic [1:0]  WATCHDOG_WINDOW_WIDTH,
    input  wire logic        SECONDARY_OSC_SELECT,
    input  wire logic        SMBUS_PROTOCOL_ENABLE,

    output cir_ctrl_t        CONTROLS,
    output logic             EXEC_ENABLE,
    output logic             REGULATOR_STANDBY,

    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] AWADDR,
    input  wire logic [2:0]  AWPROT,

    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,

    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,

    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [31:0] ARADDR,
    input  wire logic [2:0]  ARPROT,

    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP
);

    cir_st_t s_reg;
    cir_st_t s_next;

    logic [7:0]  start_len;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    logic [23:0] ar_idx;
    logic        ar_ok;
    logic        wr_go;
    logic        any_taken;
    logic [1:0]  wr_resp;

    assign ar_idx = ARADDR[25:2];
    assign ar_ok  = (ARADDR[31:26] == 6'h00);

    // the window width only lengthens the wait, so a wake with the
    // regulator kept on still pays a small guard per window step
    always_comb begin
        start_len = s_reg.standby ? REGULATOR_STARTUP_INTERVAL_CYC : REG_ON_CYC;
        start_len = 8'(start_len
                    + 8'(WATCHDOG_WINDOW_WIDTH) * GUARD_CYC);
    end

    // read decode; configuration holes read as ones
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        if (!ar_ok) begin
            rd_resp = RESP_DECERR;
        end else begin
            case (ar_idx)
                IDX_UID1:   rd_word = {8'h00, UNIQUE_ID[23:0]};
                IDX_UID2:   rd_word = {8'h00, UNIQUE_ID[47:24]};
                IDX_UID3:   rd_word = {8'h00, UNIQUE_ID[71:48]};
                IDX_UID4:   rd_word = {8'h00, UNIQUE_ID[95:72]};
                IDX_UID5:   rd_word = {8'h00, UNIQUE_ID[119:96]};

                IDX_PART_IDENTITY_WORD:  rd_word = {16'h0000, FAMILY_CODE,
                                       PART_CODE};
                IDX_SILICON_REVISION_WORD: rd_word = {28'h0000000, REVISION};

                IDX_CNTL:   rd_word = {16'h00ff, s_reg.nvm.cntl};
                IDX_CNTH:   rd_word = {16'h00ff, s_reg.nvm.cnth};
                IDX_DMT:    rd_word = {8'h00, 23'h7fffff,
                                       s_reg.nvm.dis};
                IDX_OPT:    rd_word = {8'h00, 13'h1fff,
                                       s_reg.nvm.smb,
                                       5'h1f,
                                       s_reg.nvm.i2c,
                                       s_reg.nvm.secondary_oscillator,
                                       s_reg.nvm.tmpr,
                                       s_reg.nvm.cmp,
                                       1'b1};
                IDX_CTRL:   rd_word = {19'h00000, EXEC_ENABLE,
                                       s_reg.state, s_reg.nvm.done};
                default:    rd_resp = RESP_DECERR;
            endcase
        end
    end

    always_comb begin
        s_next    = s_reg;
        wr_go     = s_reg.aw_held && s_reg.w_held;
        any_taken = 1'b0;
        wr_resp   = RESP_OKAY;

        // write address and data are taken in either order
        if (AWVALID && AWREADY) begin
            s_next.aw_held = 1'b1;
            s_next.aw_idx  = AWADDR[25:2];
            s_next.aw_ok   = (AWADDR[31:26] == 6'h00);
        end
        if (WVALID && WREADY) begin
            s_next.w_held = 1'b1;
            s_next.wdata  = WDATA[23:0];
            s_next.wstrb  = WSTRB[2:0];
        end

        // a field takes a value only while its flag is clear and the
        // lanes covering it are strobed; a word other than IDX_CTRL where
        // nothing took answers with a slave error, and IDX_CTRL always answers okay
        if (wr_go) begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;

            if (!s_reg.aw_ok) begin
                wr_resp = RESP_DECERR;
            end else begin
                case (s_reg.aw_idx)
                    IDX_CNTL: begin
                        if (!s_reg.nvm.done[F_CNTL]
                            && s_reg.wstrb[1:0] == 2'b11) begin
                            s_next.nvm.cntl         = s_reg.wdata[15:0];
                            s_next.nvm.done[F_CNTL] = 1'b1;
                            any_taken               = 1'b1;
                        end
                    end

                    IDX_CNTH: begin
                        if (!s_reg.nvm.done[F_CNTH]
                            && s_reg.wstrb[1:0] == 2'b11) begin
                            s_next.nvm.cnth         = s_reg.wdata[15:0];
                            s_next.nvm.done[F_CNTH] = 1'b1;
                            any_taken               = 1'b1;
                        end
                    end

                    IDX_DMT: begin
                        if (!s_reg.nvm.done[F_DIS] && s_reg.wstrb[0]) begin
                            s_next.nvm.dis         = s_reg.wdata[DIS_BIT];
                            s_next.nvm.done[F_DIS] = 1'b1;
                            any_taken              = 1'b1;
                        end
                    end

                    IDX_OPT: begin
                        if (!s_reg.nvm.done[F_SMB] && s_reg.wstrb[1]) begin
                            s_next.nvm.smb         = s_reg.wdata[SMB_BIT];
                            s_next.nvm.done[F_SMB] = 1'b1;
                            any_taken              = 1'b1;
                        end

                        if (s_reg.wstrb[0]) begin
                            if (!s_reg.nvm.done[F_I2C]) begin
                                s_next.nvm.i2c = s_reg.wdata[I2C_BIT];
                                s_next.nvm.done[F_I2C] = 1'b1;
                                any_taken = 1'b1;
                            end

                            if (!s_reg.nvm.done[F_SECONDARY_OSCILLATOR]) begin
                                s_next.nvm.secondary_oscillator = s_reg.wdata[SECONDARY_OSCILLATOR_BIT];
                                s_next.nvm.done[F_SECONDARY_OSCILLATOR] = 1'b1;
                                any_taken = 1'b1;
                            end

                            if (!s_reg.nvm.done[F_TMPR]) begin
                                s_next.nvm.tmpr = s_reg.wdata[TMPR_BIT];
                                s_next.nvm.done[F_TMPR] = 1'b1;
                                any_taken = 1'b1;
                            end

                            if (!s_reg.nvm.done[F_CMP]) begin
                                s_next.nvm.cmp = s_reg.wdata[CMP_BIT];
                                s_next.nvm.done[F_CMP] = 1'b1;
                                any_taken = 1'b1;
                            end
                        end
                    end

                    IDX_CTRL: begin
                        // erase touches only the configuration cells and their program-once flags
                        if (s_reg.wstrb[0] && s_reg.wdata[ERASE_BIT]) begin
                            s_next.nvm.cntl = ERASED_HALF;
                            s_next.nvm.cnth = ERASED_HALF;
                            s_next.nvm.dis  = ERASED_BIT;
                            s_next.nvm.smb  = ERASED_BIT;
                            s_next.nvm.i2c  = ERASED_BIT;
                            s_next.nvm.secondary_oscillator = ERASED_BIT;
                            s_next.nvm.tmpr = ERASED_BIT;
                            s_next.nvm.cmp  = ERASED_BIT;
                            s_next.nvm.done = FLAGS_CLEAR;
                        end
                        any_taken = 1'b1;
                    end

                    IDX_UID1, IDX_UID2, IDX_UID3, IDX_UID4, IDX_UID5,
                    IDX_PART_IDENTITY_WORD, IDX_SILICON_REVISION_WORD: begin
                        any_taken = 1'b0;
                    end

                    default: wr_resp = RESP_DECERR;
                endcase
                if (wr_resp == RESP_OKAY && !any_taken) begin
                    wr_resp = RESP_SLVERR;
                end
            end
            s_next.bresp = wr_resp;
        end else if (s_reg.bvalid && BREADY) begin
            s_next.bvalid = 1'b0;
        end

        if (ARVALID && ARREADY) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd_word;
            s_next.rresp  = rd_resp;
        end else if (s_reg.rvalid && RREADY) begin
            s_next.rvalid = 1'b0;
        end

        // execution gate and regulator sequencing
        case (s_reg.state)
            ST_LOAD: begin
                s_next.lat     = s_reg.nvm;
                s_next.standby = 1'b1;
                s_next.cnt     = REGULATOR_STARTUP_INTERVAL_CYC;
                s_next.state   = ST_START;
            end

            ST_START: begin
                if (s_reg.cnt <= 8'h01) begin
                    s_next.cnt   = 8'h00;
                    s_next.state = ST_RUN;
                end else begin
                    s_next.cnt = s_reg.cnt - 8'h01;
                end
            end

            ST_RUN: begin
                if (SLEEP_ENTER) begin
                    s_next.standby = !REG_STANDBY_CTRL;
                    s_next.state   = ST_SLEEP;
                end
            end

            ST_SLEEP: begin
                if (WAKE_EVENT) begin
                    s_next.cnt   = start_len;
                    s_next.state = ST_START;
                end
            end

            default: s_next.state = ST_LOAD;
        endcase
        // a core reset re-latches without losing programmed cells
        if (DEVICE_RESET) begin
            s_next.state = ST_LOAD;
        end

        // controls follow the latched copy, apart from the live smbus_protocol_enable and the
        // SECONDARY_OSC_SELECT gate on secondary_osc_high_power, so later programming
        // stays invisible until the next reset
        s_next.ctrl.deadman_timeout_count =
            {s_reg.lat.cnth, s_reg.lat.cntl};

        s_next.ctrl.deadman_disable =
            s_reg.lat.dis;
        s_next.ctrl.smbus_level_select =
            s_reg.lat.smb;
        s_next.ctrl.smbus_protocol_enable =
            SMBUS_PROTOCOL_ENABLE;

        s_next.ctrl.i2c_one_pin_select =
            s_reg.lat.i2c;
        s_next.ctrl.secondary_osc_high_power =
            s_reg.lat.secondary_oscillator && SECONDARY_OSC_SELECT;
        s_next.ctrl.tamper_pin_disable =
            s_reg.lat.tmpr;
        s_next.ctrl.comparator_input_relocate =
            s_reg.lat.cmp;
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_reg.state   <= ST_LOAD;
            s_reg.cnt     <= 8'h00;
            s_reg.standby <= 1'b1;

            s_reg.nvm     <= {ERASED_HALF, ERASED_HALF,
                              {6{ERASED_BIT}},
                              FLAGS_CLEAR};
            s_reg.lat     <= {ERASED_HALF, ERASED_HALF,
                              {6{ERASED_BIT}},
                              FLAGS_CLEAR};

            s_reg.ctrl    <= '0;

            s_reg.aw_held <= 1'b0;
            s_reg.aw_idx  <= 24'h000000;
            s_reg.aw_ok   <= 1'b0;
            s_reg.w_held  <= 1'b0;
            s_reg.wdata   <= 24'h000000;
            s_reg.wstrb   <= 3'h0;

            s_reg.bvalid  <= 1'b0;
            s_reg.bresp   <= RESP_OKAY;

            s_reg.rvalid  <= 1'b0;
            s_reg.rdata   <= 32'h0000_0000;
            s_reg.rresp   <= RESP_OKAY;
        end else begin
            s_reg <= s_next;
        end
    end

    // one write and one read in flight; ready drops while held
    assign AWREADY = !s_reg.aw_held && !s_reg.bvalid;
    assign WREADY  = !s_reg.w_held && !s_reg.bvalid;
    assign ARREADY = !s_reg.rvalid;

    assign BVALID  = s_reg.bvalid;
    assign BRESP   = s_reg.bresp;
    assign RVALID  = s_reg.rvalid;
    assign RDATA   = s_reg.rdata;
    assign RRESP   = s_reg.rresp;

    assign CONTROLS          = s_reg.ctrl;
    assign EXEC_ENABLE       = (s_reg.state == ST_RUN);
    assign REGULATOR_STANDBY = (s_reg.state == ST_SLEEP)
                               && s_reg.standby;

endmodule : cir_config_bank

// ===== design/cir_pkg.sv
package cir_pkg;

    // word indexes; byte address on the bus is four times the index
    localparam logic [23:0] IDX_UID1   = 24'h801600;
    localparam logic [23:0] IDX_UID2   = 24'h801602;
    localparam logic [23:0] IDX_UID3   = 24'h801604;
    localparam logic [23:0] IDX_UID4   = 24'h801606;
    localparam logic [23:0] IDX_UID5   = 24'h801608;
    localparam logic [23:0] IDX_PART_IDENTITY_WORD  = 24'hff0000;
    localparam logic [23:0] IDX_SILICON_REVISION_WORD = 24'hff0002;
    localparam logic [23:0] IDX_CNTL   = 24'hf80000;
    localparam logic [23:0] IDX_CNTH   = 24'hf80002;
    localparam logic [23:0] IDX_DMT    = 24'hf80004;
    localparam logic [23:0] IDX_OPT    = 24'hf80006;
    localparam logic [23:0] IDX_CTRL   = 24'hf80008;

    // field positions
    localparam int DIS_BIT   = 0;
    localparam int SMB_BIT   = 10;
    localparam int I2C_BIT   = 4;
    localparam int SECONDARY_OSCILLATOR_BIT  = 3;
    localparam int TMPR_BIT  = 2;
    localparam int CMP_BIT   = 1;
    localparam int ERASE_BIT = 0;

    // program-once flag positions
    localparam int F_CNTL = 0;
    localparam int F_CNTH = 1;
    localparam int F_DIS  = 2;
    localparam int F_SMB  = 3;
    localparam int F_I2C  = 4;
    localparam int F_SECONDARY_OSCILLATOR = 5;
    localparam int F_TMPR = 6;
    localparam int F_CMP  = 7;

    // reset values; erased cells read as ones
    localparam logic [15:0] ERASED_HALF = 16'hffff;
    localparam logic        ERASED_BIT  = 1'b1;
    localparam logic [7:0]  FLAGS_CLEAR = 8'h00;

    // identity values, arbitrary and neutral
    localparam logic [7:0]   FAMILY_CODE_DEF = 8'h5a;
    localparam logic [7:0]   PART_CODE_DEF   = 8'h3c;
    localparam logic [3:0]   REVISION_DEF    = 4'h1;
    localparam logic [119:0] UID_DEF         =
        120'h23456789abcdef0011223344556677;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // timing, core clock 50 ns
    localparam int CLK_PERIOD_NS = 50;
    localparam int REGULATOR_STARTUP_INTERVAL_NS      = 10000;
    localparam int REG_ON_NS     = 500;
    localparam int GUARD_NS      = 250;
    localparam logic [7:0] REGULATOR_STARTUP_INTERVAL_CYC =
        8'((REGULATOR_STARTUP_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] REG_ON_CYC =
        8'((REG_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] GUARD_CYC =
        8'((GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        ST_LOAD  = 4'b0001,
        ST_START = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_SLEEP = 4'b1000
    } cir_state_t;

    typedef struct packed {
        logic [31:0] deadman_timeout_count;
        logic        deadman_disable;
        logic        smbus_level_select;
        logic        smbus_protocol_enable;
        logic        i2c_one_pin_select;
        logic        secondary_osc_high_power;
        logic        tamper_pin_disable;
        logic        comparator_input_relocate;
    } cir_ctrl_t;

    typedef struct packed {
        logic [15:0] cntl;
        logic [15:0] cnth;
        logic        dis;
        logic        smb;
        logic        i2c;
        logic        secondary_oscillator;
        logic        tmpr;
        logic        cmp;
        logic [7:0]  done;
    } cir_nvm_t;

    typedef struct packed {
        cir_state_t  state;
        logic [7:0]  cnt;
        logic        standby;
        cir_nvm_t    nvm;
        cir_nvm_t    lat;
        cir_ctrl_t   ctrl;
        logic        aw_held;
        logic [23:0] aw_idx;
        logic        aw_ok;
        logic        w_held;
        logic [23:0] wdata;
        logic [2:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cir_st_t;

endpackage : cir_pkg
